// ==== shcs_pkg.sv ====
package shcs_pkg;
  // Register byte offsets
  localparam logic [11:0] SHCS_OFF_CTRL  = 12'hd24;
  localparam logic [11:0] SHCS_OFF_IRQST = 12'hd30;
  localparam logic [11:0] SHCS_OFF_IRQMK = 12'hd34;
  localparam logic [11:0] SHCS_OFF_PRIV  = 12'hd38;

  // Bit positions of the control and state register
  localparam int SHCS_B_MEM_ACT  = 0;
  localparam int SHCS_B_BUS_ACT  = 1;
  localparam int SHCS_B_USG_ACT  = 3;
  localparam int SHCS_B_CALL_ACT = 7;
  localparam int SHCS_B_MONA   = 8;
  localparam int SHCS_B_PSVA   = 10;
  localparam int SHCS_B_TICKA  = 11;
  localparam int SHCS_B_USGP   = 12;
  localparam int SHCS_B_MEM_PEND  = 13;
  localparam int SHCS_B_BUS_PEND  = 14;
  localparam int SHCS_B_CALL_PEND = 15;
  localparam int SHCS_B_MEMEN  = 16;
  localparam int SHCS_B_BUSEN  = 17;
  localparam int SHCS_B_USGEN  = 18;

  // Implemented bits; 9, 6:4, 2 and 31:19 read zero
  localparam logic [31:0] SHCS_RW_MASK  = 32'h0007_fd8b;
  localparam logic [31:0] SHCS_CTRL_RST = 32'h0000_0000;

  // Interrupt status bits
  localparam int SHCS_I_ESC   = 0;
  localparam int SHCS_I_DENY  = 1;
  localparam int SHCS_I_W     = 2;

  localparam logic [1:0] SHCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SHCS_RESP_SLVERR = 2'h2;

  // Fault source indices
  localparam int SHCS_F_MEM = 0;
  localparam int SHCS_F_BUS = 1;
  localparam int SHCS_F_USG = 2;

  typedef struct packed {
    logic [2:0] fault_pend;   // Mem, bus, usage fault raised
    logic       call_pend;
    logic [5:0] entry;        // Mem, bus, usg, call, psv, tick
    logic [5:0] ret;
    logic       mon_enter;
    logic       mon_exit;
  } shcs_evt_t;

  typedef enum logic [1:0] {
    SHCS_IDLE = 2'b00,
    SHCS_WRSP = 2'b01,
    SHCS_RRSP = 2'b10
  } shcs_st_t;

  typedef struct packed {
    logic [31:0]          ctrl;
    logic [SHCS_I_W-1:0]  irq_st;
    logic [SHCS_I_W-1:0]  irq_mk;
    logic                 priv_req;
    logic                 aw_got;
    logic                 w_got;
    logic [11:0]          awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 wprot;
    shcs_st_t             wst;
    logic [1:0]           bresp;
    shcs_st_t             rst;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 hard_fault;
    logic                 irq;
  } shcs_state_t;
endpackage

// ==== shcs_top.sv ====
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// Contract
// - Bit 16 enables memory management fault exception when one.
// - Bit 15 shows supervisor call pending; software write sets or clears.
// - Bit 14 shows bus fault pending; software write changes it.
// - Bit 13 shows memory fault pending; software write changes it.
// - Bit 12 shows usage fault pending; software write changes it.
// - Bit 11 shows system tick active; software write changes it.
// - Bit 10 shows pendable service active; software write changes it.
// - Bit 8 is read/write debug monitor active flag.
// - Bit 7 shows supervisor call active; software write changes it.
// - Bit 3 shows usage fault active; software write changes it.
// - Bit 1 shows bus fault active; software write changes it.
// - Bit 0 is read/write memory fault active flag.
// - Bits 9, 6:4 and 2 read zero; software preserves them.
// - All enable, pending and active flags clear on reset.
// - Bit 18 enables usage fault, bit 17 bus fault.
// - Fault with its enable clear escalates to hard fault.
// - Only privileged accesses allowed (checked only while priv_req is set); bits changed by read-modify-write.
module shcs_top
  import shcs_pkg::*;
(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_SYS_RST,
  input  wire shcs_pkg::shcs_evt_t I_EVT,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_AWADDR,
  input  wire logic [2:0]        I_AWPROT,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  output logic [1:0]             O_BRESP,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  input  wire logic [31:0]       I_ARADDR,
  input  wire logic [2:0]        I_ARPROT,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic [31:0]            O_CTRL_STATE,
  output logic                   O_HARD_FAULT,
  output logic                   O_IRQ
);
  import shcs_pkg::*;

  shcs_state_t s_q;
  shcs_state_t s_d;

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_wr;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] wmask;
  logic [31:0] hw_set;
  logic [31:0] hw_clr;
  logic [2:0]  fault_en;
  logic [2:0]  fault_raise;
  logic [SHCS_I_W-1:0] ev_irq;

  assign O_AWREADY = (s_q.wst == SHCS_IDLE) && !s_q.aw_got;
  assign O_WREADY  = (s_q.wst == SHCS_IDLE) && !s_q.w_got;
  assign O_ARREADY = (s_q.rst == SHCS_IDLE);
  assign aw_hs     = I_AWVALID && O_AWREADY;
  assign w_hs      = I_WVALID && O_WREADY;
  assign ar_hs     = I_ARVALID && O_ARREADY;

  assign O_BVALID     = (s_q.wst == SHCS_WRSP);
  assign O_BRESP      = s_q.bresp;
  assign O_RVALID     = (s_q.rst == SHCS_RRSP);
  assign O_RDATA      = s_q.rdata;
  assign O_RRESP      = s_q.rresp;
  assign O_CTRL_STATE = s_q.ctrl;
  assign O_HARD_FAULT = s_q.hard_fault;
  assign O_IRQ        = s_q.irq;

  assign fault_en = {s_q.ctrl[SHCS_B_USGEN], s_q.ctrl[SHCS_B_BUSEN],
                     s_q.ctrl[SHCS_B_MEMEN]};
  assign fault_raise = I_EVT.fault_pend & fault_en;

  always_comb begin
    logic [11:0] a;
    logic        p;
    a = 12'h000;
    p = 1'b0;
    hw_set = 32'h0000_0000;
    hw_clr = 32'h0000_0000;
    // Fault pending set when raised and enabled, call pending when raised; all cleared on entry
    hw_set[SHCS_B_MEM_PEND]  = fault_raise[SHCS_F_MEM];
    hw_set[SHCS_B_BUS_PEND]  = fault_raise[SHCS_F_BUS];
    hw_set[SHCS_B_USGP]      = fault_raise[SHCS_F_USG];
    hw_set[SHCS_B_CALL_PEND] = I_EVT.call_pend;
    hw_clr[SHCS_B_MEM_PEND]  = I_EVT.entry[0];
    hw_clr[SHCS_B_BUS_PEND]  = I_EVT.entry[1];
    hw_clr[SHCS_B_USGP]      = I_EVT.entry[2];
    hw_clr[SHCS_B_CALL_PEND] = I_EVT.entry[3];
    // Active flags follow entry and return
    hw_set[SHCS_B_MEM_ACT]  = I_EVT.entry[0];
    hw_set[SHCS_B_BUS_ACT]  = I_EVT.entry[1];
    hw_set[SHCS_B_USG_ACT]  = I_EVT.entry[2];
    hw_set[SHCS_B_CALL_ACT] = I_EVT.entry[3];
    hw_set[SHCS_B_PSVA]  = I_EVT.entry[4];
    hw_set[SHCS_B_TICKA] = I_EVT.entry[5];
    hw_set[SHCS_B_MONA]  = I_EVT.mon_enter;
    hw_clr[SHCS_B_MEM_ACT]  = I_EVT.ret[0];
    hw_clr[SHCS_B_BUS_ACT]  = I_EVT.ret[1];
    hw_clr[SHCS_B_USG_ACT]  = I_EVT.ret[2];
    hw_clr[SHCS_B_CALL_ACT] = I_EVT.ret[3];
    hw_clr[SHCS_B_PSVA]  = I_EVT.ret[4];
    hw_clr[SHCS_B_TICKA] = I_EVT.ret[5];
    hw_clr[SHCS_B_MONA]  = I_EVT.mon_exit;

    s_d = s_q;
    ev_irq = '0;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    do_wr = 1'b0;
    wmask = 32'h0000_0000;
    s_d.hard_fault = |(I_EVT.fault_pend & ~fault_en);
    ev_irq[SHCS_I_ESC] = s_d.hard_fault;

    if (aw_hs) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = I_AWADDR[11:0];
      s_d.wprot  = I_AWPROT[0];
    end
    if (w_hs) begin
      s_d.w_got = 1'b1;
      s_d.wdata = I_WDATA;
      s_d.wstrb = I_WSTRB;
    end

    if (s_d.aw_got && s_d.w_got && s_q.wst == SHCS_IDLE) begin
      a = s_d.awaddr;
      p = s_d.wprot;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.wst    = SHCS_WRSP;
      // Unprivileged writes rejected while priv_req is set so exception state stays intact
      wr_ok = p || !s_q.priv_req;
      s_d.bresp = SHCS_RESP_SLVERR;
      if (!wr_ok) begin
        ev_irq[SHCS_I_DENY] = 1'b1;
      end else begin
        for (int i = 0; i < 4; i++) begin
          wmask[i*8 +: 8] = {8{s_d.wstrb[i]}};
        end
        unique case (a)
          SHCS_OFF_CTRL: begin
            s_d.bresp = SHCS_RESP_OKAY;
            do_wr = 1'b1;
          end
          SHCS_OFF_IRQST: begin
            s_d.bresp = SHCS_RESP_OKAY;
            s_d.irq_st = s_q.irq_st & ~s_d.wdata[SHCS_I_W-1:0];
          end
          SHCS_OFF_IRQMK: begin
            s_d.bresp = SHCS_RESP_OKAY;
            s_d.irq_mk = s_d.wdata[SHCS_I_W-1:0];
          end
          SHCS_OFF_PRIV: begin
            s_d.bresp = SHCS_RESP_OKAY;
            s_d.priv_req = s_d.wdata[0];
          end
          default: ;
        endcase
      end
    end
    if (s_q.wst == SHCS_WRSP && I_BREADY) begin
      s_d.wst = SHCS_IDLE;
    end

    // Software write lands first; a hardware event in the same cycle wins
    wmask = wmask & SHCS_RW_MASK & {32{do_wr}};
    s_d.ctrl = (s_q.ctrl & ~wmask) | (s_d.wdata & wmask);
    s_d.ctrl = (s_d.ctrl & ~hw_clr) | hw_set;
    s_d.ctrl = s_d.ctrl & SHCS_RW_MASK;

    if (ar_hs) begin
      s_d.rst = SHCS_RRSP;
      rd_ok = I_ARPROT[0] || !s_q.priv_req;
      s_d.rresp = SHCS_RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      if (!rd_ok) begin
        ev_irq[SHCS_I_DENY] = 1'b1;
      end else begin
        unique case (I_ARADDR[11:0])
          SHCS_OFF_CTRL: begin
            s_d.rresp = SHCS_RESP_OKAY;
            s_d.rdata = s_q.ctrl & SHCS_RW_MASK;
          end
          SHCS_OFF_IRQST: begin
            s_d.rresp = SHCS_RESP_OKAY;
            s_d.rdata[SHCS_I_W-1:0] = s_q.irq_st;
          end
          SHCS_OFF_IRQMK: begin
            s_d.rresp = SHCS_RESP_OKAY;
            s_d.rdata[SHCS_I_W-1:0] = s_q.irq_mk;
          end
          SHCS_OFF_PRIV: begin
            s_d.rresp = SHCS_RESP_OKAY;
            s_d.rdata[0] = s_q.priv_req;
          end
          default: ;
        endcase
      end
    end else if (s_q.rst == SHCS_RRSP && I_RREADY) begin
      s_d.rst = SHCS_IDLE;
    end

    // Set beats the clear in the same cycle
    s_d.irq_st = s_d.irq_st | ev_irq;
    s_d.irq = |(s_d.irq_st & s_d.irq_mk);
    if (I_SYS_RST) begin
      s_d = '0;
      s_d.ctrl = SHCS_CTRL_RST;
      s_d.wst = SHCS_IDLE;
      s_d.rst = SHCS_IDLE;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    s_q <= s_d;
  end
endmodule

// ==== shcs_monitor.sv ====
`timescale 1ns/100ps
module shcs_monitor
  import shcs_pkg::*;
(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_SYS_RST,
  input  wire shcs_pkg::shcs_evt_t I_EVT,
  input  wire logic [31:0]       O_CTRL_STATE,
  input  wire logic              O_HARD_FAULT
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);

  a_reserved_zero: assert property (
    (O_CTRL_STATE & ~SHCS_RW_MASK) == 32'h0)
    else $error("reserved control bits not zero");
  a_reset_clear: assert property (
    $past(I_SYS_RST) |-> O_CTRL_STATE == 32'h0)
    else $error("control state not clear after reset");
  a_fault_escalate: assert property (
    (I_EVT.fault_pend & ~O_CTRL_STATE[18:16]) != 3'h0 |=> O_HARD_FAULT)
    else $error("disabled fault did not escalate");
  a_hard_cause: assert property (O_HARD_FAULT |->
    ($past(I_EVT.fault_pend) & ~$past(O_CTRL_STATE[18:16])) != 3'h0)
    else $error("hard fault without a disabled fault");
  a_mem_pending: assert property (
    I_EVT.fault_pend[0] && O_CTRL_STATE[16] && !I_EVT.entry[0]
    |=> O_CTRL_STATE[13]) else $error("memory fault pending not set");
  a_call_entry: assert property (
    I_EVT.entry[3] && !I_EVT.call_pend && !I_EVT.ret[3]
    |=> O_CTRL_STATE[7] && !O_CTRL_STATE[15])
    else $error("supervisor entry flags wrong");
  a_tick_return: assert property (
    I_EVT.ret[5] && !I_EVT.entry[5] |=> !O_CTRL_STATE[11])
    else $error("tick active not cleared on return");
  a_monitor_enter: assert property (
    I_EVT.mon_enter && !I_EVT.mon_exit |=> O_CTRL_STATE[8])
    else $error("debug monitor active not set");
endmodule

bind shcs_top shcs_monitor i_shcs_monitor (.*);

// ==== shcs_tb_top.sv ====
`timescale 1ns/100ps
module shcs_tb_top;
  import shcs_pkg::*;
  logic        I_CLK_SYS, I_SYS_RST, I_AWVALID, I_WVALID, I_BREADY;
  logic        I_ARVALID, I_RREADY, O_AWREADY, O_WREADY, O_BVALID;
  logic        O_ARREADY, O_RVALID, O_HARD_FAULT, O_IRQ;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA, O_CTRL_STATE;
  logic [2:0]  I_AWPROT, I_ARPROT;
  logic [3:0]  I_WSTRB;
  logic [1:0]  O_BRESP, O_RRESP;
  shcs_evt_t   I_EVT;
  int          fail_count, total_checks;

  shcs_top i_shcs_top (.*);

  initial begin
    I_CLK_SYS = 1'b0;
    forever #25 I_CLK_SYS = ~I_CLK_SYS;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Handshakes judged at the falling edge, where the next rising edge's
  // values already stand; avoids racing the design's own update
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [2:0] p,
                    input logic [1:0] er);
    logic       aw, w, ah, wh, bv;
    logic [1:0] br;
    aw = 1'b0;
    w = 1'b0;
    bv = 1'b0;
    br = 2'h0;
    I_AWADDR <= {20'h0, a};
    I_AWPROT <= p;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(negedge I_CLK_SYS);
      ah = I_AWVALID && O_AWREADY;
      wh = I_WVALID && O_WREADY;
      @(posedge I_CLK_SYS);
      if (ah) begin
        aw = 1'b1;
        I_AWVALID <= 1'b0;
      end
      if (wh) begin
        w = 1'b1;
        I_WVALID <= 1'b0;
      end
    end
    while (bv !== 1'b1) begin
      @(negedge I_CLK_SYS);
      bv = O_BVALID;
      br = O_BRESP;
      @(posedge I_CLK_SYS);
    end
    chk("write response", {30'h0, er}, {30'h0, br});
  endtask

  task automatic rd(input logic [11:0] a, input logic [2:0] p,
                    input logic [31:0] ed, input logic [1:0] er);
    logic        ah, rv;
    logic [31:0] rdat;
    logic [1:0]  rr;
    ah = 1'b0;
    rv = 1'b0;
    rdat = 32'h0000_0000;
    rr = 2'h0;
    I_ARADDR <= {20'h0, a};
    I_ARPROT <= p;
    I_ARVALID <= 1'b1;
    while (ah !== 1'b1) begin
      @(negedge I_CLK_SYS);
      ah = I_ARVALID && O_ARREADY;
      @(posedge I_CLK_SYS);
    end
    I_ARVALID <= 1'b0;
    while (rv !== 1'b1) begin
      @(negedge I_CLK_SYS);
      rv = O_RVALID;
      rdat = O_RDATA;
      rr = O_RRESP;
      @(posedge I_CLK_SYS);
    end
    chk("read data", ed, rdat);
    chk("read response", {30'h0, er}, {30'h0, rr});
  endtask

  // Hard fault stands one cycle only, so judged mid-cycle after the event
  task automatic pulse(input shcs_evt_t e, input logic [31:0] exp,
                       input logic hf);
    I_EVT <= e;
    @(posedge I_CLK_SYS);
    I_EVT <= '0;
    @(negedge I_CLK_SYS);
    chk("control state", exp, O_CTRL_STATE);
    chk("hard fault", {31'h0, hf}, {31'h0, O_HARD_FAULT});
    @(posedge I_CLK_SYS);
  endtask

  task automatic t_regs();
    rd(SHCS_OFF_CTRL, 3'h1, 32'h0, SHCS_RESP_OKAY);
    wr(SHCS_OFF_CTRL, 32'hffff_ffff, 4'hf, 3'h1, SHCS_RESP_OKAY);
    rd(SHCS_OFF_CTRL, 3'h1, SHCS_RW_MASK, SHCS_RESP_OKAY);
    wr(SHCS_OFF_CTRL, 32'h0, 4'h2, 3'h1, SHCS_RESP_OKAY);
    rd(SHCS_OFF_CTRL, 3'h1, 32'h0007_008b, SHCS_RESP_OKAY);
  endtask

  task automatic t_irq();
    shcs_evt_t e;
    wr(SHCS_OFF_CTRL, 32'h0, 4'hf, 3'h1, SHCS_RESP_OKAY);
    for (int f = 0; f < 3; f++) begin
      e = '0;
      e.fault_pend[f] = 1'b1;
      pulse(e, 32'h0, 1'b1);
    end
    rd(SHCS_OFF_IRQST, 3'h1, 32'h1, SHCS_RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, O_IRQ});
    wr(SHCS_OFF_IRQMK, 32'h1, 4'hf, 3'h1, SHCS_RESP_OKAY);
    repeat (2) @(posedge I_CLK_SYS);
    chk("irq raised", 32'h1, {31'h0, O_IRQ});
    wr(SHCS_OFF_IRQST, 32'h1, 4'hf, 3'h1, SHCS_RESP_OKAY);
    repeat (2) @(posedge I_CLK_SYS);
    chk("irq cleared", 32'h0, {31'h0, O_IRQ});
  endtask

  task automatic t_events();
    int          act[6] = '{0, 1, 3, 7, 10, 11};
    int          pnd[4] = '{13, 14, 12, 15};
    logic [31:0] base;
    shcs_evt_t   e;
    base = 32'h0007_0000;
    wr(SHCS_OFF_CTRL, base, 4'hf, 3'h1, SHCS_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      if (i < 4) begin
        e = '0;
        if (i == 3) begin
          e.call_pend = 1'b1;
        end else begin
          e.fault_pend[i] = 1'b1;
        end
        pulse(e, base | (32'h1 << pnd[i]), 1'b0);
      end
      e = '0;
      e.entry[i] = 1'b1;
      pulse(e, base | (32'h1 << act[i]), 1'b0);
      e = '0;
      e.ret[i] = 1'b1;
      pulse(e, base, 1'b0);
    end
    e = '0;
    e.mon_enter = 1'b1;
    pulse(e, base | 32'h100, 1'b0);
    e = '0;
    e.mon_exit = 1'b1;
    pulse(e, base, 1'b0);
    // Active bit changed by software, then the saved state put back
    rd(SHCS_OFF_CTRL, 3'h1, base, SHCS_RESP_OKAY);
    wr(SHCS_OFF_CTRL, base | 32'h800, 4'hf, 3'h1, SHCS_RESP_OKAY);
    rd(SHCS_OFF_CTRL, 3'h1, base | 32'h800, SHCS_RESP_OKAY);
    wr(SHCS_OFF_CTRL, base, 4'hf, 3'h1, SHCS_RESP_OKAY);
    rd(SHCS_OFF_CTRL, 3'h1, base, SHCS_RESP_OKAY);
  endtask

  // Denied access must leave control state untouched
  task automatic t_priv();
    wr(SHCS_OFF_PRIV, 32'h1, 4'hf, 3'h0, SHCS_RESP_OKAY);
    wr(SHCS_OFF_CTRL, 32'h1, 4'hf, 3'h0, SHCS_RESP_SLVERR);
    rd(SHCS_OFF_CTRL, 3'h1, 32'h0007_0000, SHCS_RESP_OKAY);
    rd(SHCS_OFF_IRQST, 3'h1, 32'h2, SHCS_RESP_OKAY);
    rd(12'hd3c, 3'h1, 32'h0, SHCS_RESP_SLVERR);
    wr(SHCS_OFF_PRIV, 32'h0, 4'hf, 3'h1, SHCS_RESP_OKAY);
  endtask

  initial begin
    I_SYS_RST = 1'b1;
    I_EVT = '0;
    {I_AWVALID, I_WVALID, I_ARVALID} = 3'h0;
    {I_AWADDR, I_WDATA, I_ARADDR} = '0;
    {I_AWPROT, I_ARPROT, I_WSTRB} = '0;
    I_BREADY = 1'b1;
    I_RREADY = 1'b1;
    repeat (4) @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'b0;
    t_regs();
    t_irq();
    t_events();
    t_priv();
    finish_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge I_CLK_SYS);
    fail_count++;
    finish_test();
  end
endmodule
